/* File: design/ebw_pkg.sv */
// Constants, register map and field layout of the external bus window block
package ebw_pkg;
    localparam int AXI_AW = 18;
    localparam int AXI_DW = 32;
    localparam int REG_W = 16;

    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_READBACK = 16'hF108;
    localparam logic [15:0] IDX_WIN4 = 16'hFF1A;
    localparam logic [15:0] IDX_WIN0 = 16'hFF0C;
    localparam logic [15:0] IDX_CMD = 16'hFF80;
    localparam logic [15:0] IDX_STAT = 16'hFF82;

    // Window control fields
    localparam int F_WAIT_LO = 0;
    localparam int F_WAIT_HI = 3;
    localparam int F_CMD_DELAY = 4;
    localparam int F_TURN = 5;
    localparam int F_FORM_LO = 6;
    localparam int F_FORM_HI = 7;
    localparam int F_LATCH_LEN = 9;
    localparam int F_ACTIVE = 10;
    localparam int F_HS_EN = 12;
    localparam int F_HS_POL = 13;
    localparam int F_SEL_RD = 14;
    localparam int F_SEL_ST = 15;
    localparam logic [15:0] WIN_RW_MASK = 16'hF6FF;
    localparam logic [15:0] WIN_RESET = 16'h0000;
    localparam logic [3:0] WAIT_MAX = 4'hF;

    // Readback fields
    localparam int RB_STORE_CFG = 0;
    localparam int RB_SEL_LO = 1;
    localparam int RB_SEL_HI = 2;
    localparam int RB_SEG_LO = 3;
    localparam int RB_SEG_HI = 4;
    localparam int RB_CLK_LO = 5;
    localparam int RB_CLK_HI = 7;
    localparam int PORT_FORM_LO = 6;
    localparam int PORT_FORM_HI = 7;
    localparam int PORT_W = 8;

    // Command and status fields
    localparam int C_STORE = 0;
    localparam int C_WIN4 = 1;
    localparam int C_LO = 2;
    localparam int C_HI = 3;
    localparam int S_BUSY = 0;
    localparam int S_SPLIT = 1;
    localparam int S_REFUSED = 2;

    // Bus timing: one aclk cycle stands for one half clock period
    localparam int CLK_MHZ = 200;
    localparam int HALF_CLOCK_PERIOD_NS = 5;
    localparam int HALF_CLOCK_CYCLES = (HALF_CLOCK_PERIOD_NS * CLK_MHZ + 999) / 1000;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [1:0] {
        FORM_DEMUX8,
        FORM_MUX8,
        FORM_DEMUX16,
        FORM_MUX16
    } ebw_form_e;
endpackage : ebw_pkg

/* File: design/ebw_cyc_if.sv */
// Request and configuration link between register file and cycle sequencer
`timescale 1ns/100ps
`default_nettype none
interface ebw_cyc_if;
    logic [15:0] cfg;
    logic start;
    logic is_store;
    logic lo_byte;
    logic hi_byte;
    logic split_mode;
    logic use_cs;
    logic [4:0] cs_lines;
    logic busy;
    modport ctl (output cfg, start, is_store, lo_byte, hi_byte, split_mode, use_cs, cs_lines,
        input busy);
    modport seq (input cfg, start, is_store, lo_byte, hi_byte, split_mode, use_cs, cs_lines,
        output busy);
endinterface : ebw_cyc_if
`default_nettype wire

/* File: design/ebw_cycle_seq.sv */
// External bus cycle sequencer: latch strobe, command, waits, turnaround
`timescale 1ns/100ps
`default_nettype none
module ebw_cycle_seq (
    input wire logic aclk,
    input wire logic aresetn,
    ebw_cyc_if.seq cyc,
    input wire logic ready_level,
    output logic ale,
    output logic rd_n,
    output logic wr_n,
    output logic bhe_n,
    output logic [4:0] cs_n
);
    import ebw_pkg::*;

    typedef enum logic [2:0] {ST_IDLE, ST_LATCH, ST_DELAY, ST_CMD, ST_TURN} ebw_state_e;

    ebw_state_e state_reg;
    logic [15:0] cfg_reg;
    logic [3:0] count_reg;
    logic store_reg;
    logic lo_reg;
    logic hi_reg;
    logic split_reg;
    logic cs_ok_reg;
    logic [4:0] lines_reg;
    logic cmd_on;
    logic cs_on;
    logic [3:0] waits;

    assign cyc.busy = (state_reg != ST_IDLE);
    assign waits = WAIT_MAX - cfg_reg[F_WAIT_HI:F_WAIT_LO];
    assign cmd_on = (state_reg == ST_CMD);

    always_comb begin
        if (state_reg == ST_IDLE || state_reg == ST_TURN) begin
            cs_on = 1'b0;
        end else if (!store_reg && cfg_reg[F_SEL_RD]) begin
            cs_on = cmd_on;
        end else if (store_reg && cfg_reg[F_SEL_ST]) begin
            cs_on = cmd_on;
        end else begin
            cs_on = 1'b1;
        end
    end

    // Configuration is frozen for the whole cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_reg <= WIN_RESET;
            store_reg <= 1'b0;
            lo_reg <= 1'b0;
            hi_reg <= 1'b0;
            split_reg <= 1'b0;
            cs_ok_reg <= 1'b0;
            lines_reg <= 5'h00;
        end else if (state_reg == ST_IDLE && cyc.start) begin
            cfg_reg <= cyc.cfg;
            store_reg <= cyc.is_store;
            lo_reg <= cyc.lo_byte;
            hi_reg <= cyc.hi_byte;
            split_reg <= cyc.split_mode;
            cs_ok_reg <= cyc.use_cs;
            lines_reg <= cyc.cs_lines;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= ST_IDLE;
            count_reg <= 4'h0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (cyc.start) begin
                        state_reg <= ST_LATCH;
                        count_reg <= cyc.cfg[F_LATCH_LEN] ? 4'h1 : 4'h0;
                    end
                end
                ST_LATCH: begin
                    if (count_reg != 4'h0) begin
                        count_reg <= count_reg - 4'h1;
                    end else if (!cfg_reg[F_CMD_DELAY]) begin
                        state_reg <= ST_DELAY;
                        count_reg <= 4'(HALF_CLOCK_CYCLES - 1);
                    end else begin
                        state_reg <= ST_CMD;
                        count_reg <= waits;
                    end
                end
                ST_DELAY: begin
                    if (count_reg != 4'h0) begin
                        count_reg <= count_reg - 4'h1;
                    end else begin
                        state_reg <= ST_CMD;
                        count_reg <= waits;
                    end
                end
                ST_CMD: begin
                    if (cfg_reg[F_HS_EN] ? (ready_level == cfg_reg[F_HS_POL])
                                         : (count_reg == 4'h0)) begin
                        state_reg <= cfg_reg[F_TURN] ? ST_IDLE : ST_TURN;
                    end else if (count_reg != 4'h0) begin
                        count_reg <= count_reg - 4'h1;
                    end
                end
                ST_TURN: begin
                    state_reg <= ST_IDLE;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Pin drivers, one cycle behind the state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ale <= 1'b0;
            rd_n <= 1'b1;
            wr_n <= 1'b1;
            bhe_n <= 1'b1;
            cs_n <= 5'h1F;
        end else begin
            ale <= (state_reg == ST_LATCH);
            rd_n <= !(cmd_on && !store_reg);
            if (split_reg) begin
                wr_n <= !(cmd_on && store_reg && lo_reg);
                bhe_n <= !(cmd_on && store_reg && hi_reg);
            end else begin
                wr_n <= !(cmd_on && store_reg);
                bhe_n <= !((state_reg != ST_IDLE) && hi_reg);
            end
            cs_n <= ~(lines_reg & {cs_on && cs_ok_reg, 4'h0});
        end
    end
endmodule : ebw_cycle_seq
`default_nettype wire

/* File: design/ebw_top.sv */
// External bus window configuration: register file, reset straps, bus pins
`timescale 1ns/100ps
`default_nettype none
module ebw_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ebw_pkg::AXI_AW-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [ebw_pkg::AXI_DW-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ebw_pkg::AXI_AW-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [ebw_pkg::AXI_DW-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [ebw_pkg::PORT_W-1:0] boot_config_port,
    input wire logic external_access_pin,
    input wire logic long_hw_reset,
    input wire logic ready_pin,
    output logic ale,
    output logic rd_n,
    output logic wr_n,
    output logic bhe_n,
    output logic [4:0] cs_n,
    output logic [7:0] segment_line_enable,
    output logic bus_is_16bit,
    output logic bus_is_multiplexed,
    output logic [2:0] cpu_clock_multiplier,
    output logic store_strobe_mode
);
    import ebw_pkg::*;

    ebw_cyc_if cyc ();

    // Chip select lines enabled by the latched count
    function automatic logic [4:0] cs_line_mask(input logic [1:0] cnt);
        case (cnt)
            2'h0: cs_line_mask = 5'h07;
            2'h1: cs_line_mask = 5'h03;
            2'h2: cs_line_mask = 5'h00;
            default: cs_line_mask = 5'h1F;
        endcase
    endfunction : cs_line_mask

    // Segment address outputs enabled by the latched count
    function automatic logic [7:0] seg_line_mask(input logic [1:0] cnt);
        case (cnt)
            2'h0: seg_line_mask = 8'h0F;
            2'h1: seg_line_mask = 8'h00;
            2'h2: seg_line_mask = 8'hFF;
            default: seg_line_mask = 8'h03;
        endcase
    endfunction : seg_line_mask

    function automatic logic [15:0] word_index(input logic [AXI_AW-1:0] a);
        word_index = a[AXI_AW-1:2];
    endfunction : word_index

    // Pin synchronisers: three stages, change taken when stages two and three agree
    localparam int SYNC_W = PORT_W + 3;
    logic [SYNC_W-1:0] sync1_reg;
    logic [SYNC_W-1:0] sync2_reg;
    logic [SYNC_W-1:0] sync3_reg;
    logic [SYNC_W-1:0] filt_reg;
    logic [PORT_W-1:0] port_filt;
    logic ea_filt;
    logic long_filt;
    logic ready_filt;

    always_ff @(posedge aclk) begin
        sync1_reg <= {ready_pin, long_hw_reset, external_access_pin, boot_config_port};
        sync2_reg <= sync1_reg;
        sync3_reg <= sync2_reg;
    end

    genvar gi;
    generate
        for (gi = 0; gi < SYNC_W; gi = gi + 1) begin : g_filt
            always_ff @(posedge aclk) begin
                if (sync2_reg[gi] == sync3_reg[gi]) begin
                    filt_reg[gi] <= sync3_reg[gi];
                end
            end
        end
    endgenerate

    assign port_filt = filt_reg[PORT_W-1:0];
    assign ea_filt = filt_reg[PORT_W];
    assign long_filt = filt_reg[PORT_W+1];
    assign ready_filt = filt_reg[PORT_W+2];

    // Registers
    logic [7:0] readback_reg;
    logic [15:0] win0_reg;
    logic [15:0] win4_reg;
    logic refused_reg;
    logic start_reg;
    logic store_reg;
    logic lo_reg;
    logic hi_reg;
    logic win4_sel_reg;

    // Reset-time strap capture; port pull-ups default every field to ones
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            readback_reg[RB_SEG_HI:RB_STORE_CFG] <= port_filt[RB_SEG_HI:RB_STORE_CFG];
            if (long_filt) begin
                readback_reg[RB_CLK_HI:RB_CLK_LO] <= port_filt[RB_CLK_HI:RB_CLK_LO];
            end
        end
    end

    // AXI write path
    logic aw_held_reg;
    logic w_held_reg;
    logic [15:0] aw_idx_reg;
    logic [15:0] wdata_reg;
    logic [1:0] wstrb_reg;
    logic do_write;
    logic [15:0] wmask;

    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
    assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
    assign wmask = {{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_idx_reg <= 16'h0000;
            wdata_reg <= 16'h0000;
            wstrb_reg <= 2'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                aw_idx_reg <= word_index(s_axi_awaddr);
            end else if (do_write) begin
                aw_held_reg <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                wdata_reg <= s_axi_wdata[15:0];
                wstrb_reg <= s_axi_wstrb[1:0];
            end else if (do_write) begin
                w_held_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            case (aw_idx_reg)
                IDX_WIN0, IDX_WIN4, IDX_CMD, IDX_STAT: s_axi_bresp <= RESP_OKAY;
                IDX_READBACK: s_axi_bresp <= RESP_SLVERR;
                default: s_axi_bresp <= RESP_DECERR;
            endcase
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Window control registers; reset values depend on straps
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            win4_reg <= WIN_RESET;
            win4_reg[F_FORM_HI:F_FORM_LO] <= port_filt[PORT_FORM_HI:PORT_FORM_LO];
            win0_reg <= WIN_RESET;
            if (!ea_filt) begin
                win0_reg[F_ACTIVE] <= 1'b1;
                win0_reg[F_LATCH_LEN] <= 1'b1;
                win0_reg[F_FORM_HI:F_FORM_LO] <= port_filt[PORT_FORM_HI:PORT_FORM_LO];
            end
        end else if (do_write) begin
            if (aw_idx_reg == IDX_WIN4) begin
                win4_reg <= (win4_reg & ~(wmask & WIN_RW_MASK))
                          | (wdata_reg & wmask & WIN_RW_MASK);
            end
            if (aw_idx_reg == IDX_WIN0) begin
                win0_reg <= (win0_reg & ~(wmask & WIN_RW_MASK))
                          | (wdata_reg & wmask & WIN_RW_MASK);
            end
        end
    end

    // Cycle launch; a command on an inactive window or while busy is refused
    logic cmd_write;
    logic win_active;

    assign cmd_write = do_write && (aw_idx_reg == IDX_CMD) && wstrb_reg[0];
    assign win_active = wdata_reg[C_WIN4] ? win4_reg[F_ACTIVE] : win0_reg[F_ACTIVE];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            start_reg <= 1'b0;
            store_reg <= 1'b0;
            lo_reg <= 1'b0;
            hi_reg <= 1'b0;
            win4_sel_reg <= 1'b0;
        end else begin
            start_reg <= cmd_write && win_active && !cyc.busy && !start_reg;
            if (cmd_write && !cyc.busy && !start_reg) begin
                store_reg <= wdata_reg[C_STORE];
                lo_reg <= wdata_reg[C_LO];
                hi_reg <= wdata_reg[C_HI];
                win4_sel_reg <= wdata_reg[C_WIN4];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            refused_reg <= 1'b0;
        end else if (cmd_write && (!win_active || cyc.busy || start_reg)) begin
            refused_reg <= 1'b1;
        end else if (do_write && aw_idx_reg == IDX_STAT && wstrb_reg[0] && wdata_reg[S_REFUSED]) begin
            refused_reg <= 1'b0;
        end
    end

    assign cyc.start = start_reg;
    assign cyc.cfg = win4_sel_reg ? win4_reg : win0_reg;
    assign cyc.is_store = store_reg;
    assign cyc.lo_byte = lo_reg;
    assign cyc.hi_byte = hi_reg;
    assign cyc.split_mode = store_strobe_mode;
    assign cyc.use_cs = win4_sel_reg;
    assign cyc.cs_lines = cs_line_mask(readback_reg[RB_SEL_HI:RB_SEL_LO]);

    // AXI read path
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
            case (word_index(s_axi_araddr))
                IDX_READBACK: s_axi_rdata[7:0] <= readback_reg;
                IDX_WIN4: s_axi_rdata[15:0] <= win4_reg & WIN_RW_MASK;
                IDX_WIN0: s_axi_rdata[15:0] <= win0_reg & WIN_RW_MASK;
                IDX_CMD: s_axi_rdata[3:0] <= {hi_reg, lo_reg, win4_sel_reg, store_reg};
                IDX_STAT: s_axi_rdata[2:0] <= {refused_reg, store_strobe_mode, cyc.busy};
                default: s_axi_rresp <= RESP_DECERR;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    assign s_axi_arready = !s_axi_rvalid;

    // Configuration outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            segment_line_enable <= 8'h00;
            bus_is_16bit <= 1'b0;
            bus_is_multiplexed <= 1'b0;
            cpu_clock_multiplier <= 3'h0;
            store_strobe_mode <= 1'b0;
        end else begin
            segment_line_enable <= seg_line_mask(readback_reg[RB_SEG_HI:RB_SEG_LO]);
            bus_is_16bit <= win4_reg[F_FORM_HI];
            bus_is_multiplexed <= win4_reg[F_FORM_LO];
            cpu_clock_multiplier <= readback_reg[RB_CLK_HI:RB_CLK_LO];
            store_strobe_mode <= !readback_reg[RB_STORE_CFG];
        end
    end

    ebw_cycle_seq u_seq (
        .aclk(aclk),
        .aresetn(aresetn),
        .cyc(cyc),
        .ready_level(ready_filt),
        .ale(ale),
        .rd_n(rd_n),
        .wr_n(wr_n),
        .bhe_n(bhe_n),
        .cs_n(cs_n)
    );
endmodule : ebw_top
`default_nettype wire

/* File: testbench/ebw_top_asserts.sv */
// Concurrent checks on the external bus window ports
`timescale 1ns/100ps
`default_nettype none
module ebw_top_asserts (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [ebw_pkg::AXI_DW-1:0] s_axi_rdata,
    input wire logic ale,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic bhe_n,
    input wire logic [4:0] cs_n,
    input wire logic [7:0] segment_line_enable,
    input wire logic [2:0] cpu_clock_multiplier,
    input wire logic store_strobe_mode
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    AST_CMD_AFTER_LATCH: assert property (
        ($fell(rd_n) || $fell(wr_n)) |-> ($past(ale) || $past(ale, 2)))
        else $error("command not tied to latch strobe");
    AST_LATCH_WIDTH: assert property ($rose(ale) |-> ##[1:2] !ale)
        else $error("latch strobe too long");
    AST_CMD_BOUND: assert property ($fell(rd_n) |-> ##[1:16] rd_n)
        else $error("read command too long");
    AST_ONE_COMMAND: assert property (!rd_n |-> wr_n)
        else $error("read and store together");
    AST_SELECT_LINES: assert property (cs_n[3:0] == 4'hF)
        else $error("unused select asserted");
    AST_CFG_STEADY: assert property (
        ($past(aresetn) && $past(aresetn, 2)) |-> $stable({segment_line_enable, cpu_clock_multiplier,
        store_strobe_mode}))
        else $error("strap outputs moved");
    AST_CS_IN_FRAME: assert property (
        !cs_n[4] |-> (ale || $past(ale) || !rd_n || !wr_n || !bhe_n))
        else $error("select outside frame");
    AST_LATCH_FIRST: assert property ($rose(ale) |-> (rd_n && wr_n))
        else $error("latch strobe during command");
    AST_RDATA_HOLD: assert property (
        (s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata)))
        else $error("read data not held");
endmodule : ebw_top_asserts
bind ebw_top ebw_top_asserts u_chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .ale(ale), .rd_n(rd_n), .wr_n(wr_n), .bhe_n(bhe_n), .cs_n(cs_n),
    .segment_line_enable(segment_line_enable), .cpu_clock_multiplier(cpu_clock_multiplier),
    .store_strobe_mode(store_strobe_mode));
`default_nettype wire

/* File: testbench/ebw_mem_model.sv */
// Far-side memory model answering on the ready pin
`timescale 1ns/100ps
`default_nettype none
module ebw_mem_model (
    input wire logic aclk,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic bhe_n,
    input wire logic pol,
    input wire logic [3:0] dly,
    output logic ready_pin
);
    logic [3:0] cnt = 4'h0;
    initial ready_pin = 1'b1;
    always @(posedge aclk) begin
        if (rd_n && wr_n && bhe_n) begin
            cnt <= 4'h0;
            ready_pin <= !pol;
        end else begin
            if (cnt != 4'hF) cnt <= cnt + 4'h1;
            ready_pin <= (cnt >= dly) ? pol : !pol;
        end
    end
endmodule : ebw_mem_model
`default_nettype wire

/* File: testbench/tb_top.sv */
// Self-checking bench for the external bus window block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import ebw_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [17:0] awaddr = 18'h0;
    logic [17:0] araddr = 18'h0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic ale, rd_n, wr_n, bhe_n, b16, bmux, ssm, rdy, pol = 1'b0;
    logic [4:0] cs_n;
    logic [7:0] seg;
    logic [2:0] clkm;
    logic [3:0] dly = 4'h1;
    logic ea = 1'b1;
    logic [7:0] n_rd, n_wr, n_bhe, n_cs;
    logic [31:0] tab [5] = '{32'h043F_0006, 32'h062C_0006, 32'h443F_0006, 32'h84FF_000F,
        32'h0430_0006};
    logic [31:0] exp_n [5] = '{32'h0100_0002, 32'h0400_0007, 32'h0100_0001, 32'h0001_0101,
        32'h1000_0011};
    int err_count = 0;
    int samples_checked = 0;
    always #2.5 aclk = ~aclk;
    ebw_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .boot_config_port(8'h86),
        .external_access_pin(ea), .long_hw_reset(1'b1), .ready_pin(rdy), .ale(ale),
        .rd_n(rd_n), .wr_n(wr_n), .bhe_n(bhe_n), .cs_n(cs_n), .segment_line_enable(seg),
        .bus_is_16bit(b16), .bus_is_multiplexed(bmux), .cpu_clock_multiplier(clkm),
        .store_strobe_mode(ssm));
    ebw_mem_model u_mem (.aclk(aclk), .rd_n(rd_n), .wr_n(wr_n), .bhe_n(bhe_n), .pol(pol),
        .dly(dly), .ready_pin(rdy));
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t value %h expected %h", $time, got, exp);
        end
    endtask : check_val
    task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t response %h expected %h", $time, got, exp);
        end
    endtask : check_resp
    task automatic wr(input logic [15:0] idx, input logic [31:0] d, input logic [1:0] er);
        logic [1:0] r;
        r = 2'bxx;
        @(posedge aclk);
        awaddr <= {idx, 2'b00};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
        check_resp(r, er);
    endtask : wr
    task automatic rd(input logic [15:0] idx, input logic [31:0] ed, input logic [1:0] er);
        logic [1:0] r;
        logic [31:0] d;
        r = 2'bxx;
        d = 'x;
        @(posedge aclk);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                r = rresp;
                d = rdata;
                rready <= 1'b0;
                break;
            end
        end
        check_resp(r, er);
        check_val(d, ed);
    endtask : rd
    task automatic run_cycle(input logic [15:0] cfg, input logic [15:0] cmd);
        wr(IDX_WIN4, {16'h0, cfg}, RESP_OKAY);
        wr(IDX_CMD, {16'h0, cmd}, RESP_OKAY);
        {n_rd, n_wr, n_bhe, n_cs} = 32'h0;
        repeat (40) begin
            @(posedge aclk);
            n_rd += {7'h0, rd_n === 1'b0};
            n_wr += {7'h0, wr_n === 1'b0};
            n_bhe += {7'h0, bhe_n === 1'b0};
            n_cs += {7'h0, cs_n[4] === 1'b0};
        end
    endtask : run_cycle
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict
    initial begin
        #100000;
        err_count++;
        give_verdict();
    end
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        check_val({18'h0, clkm, seg, ssm, b16, bmux}, {18'h0, 3'h4, 8'h0F, 3'b110});
        rd(IDX_READBACK, 32'h86, RESP_OKAY);
        wr(IDX_READBACK, 32'h0, RESP_SLVERR);
        rd(IDX_READBACK, 32'h86, RESP_OKAY);
        rd(IDX_WIN0, 32'h0, RESP_OKAY);
        rd(IDX_WIN4, 32'h80, RESP_OKAY);
        rd(16'h0004, 32'h0, RESP_DECERR);
        $display("test straps done");
        wr(IDX_WIN4, 32'hFFFF, RESP_OKAY);
        rd(IDX_WIN4, {16'h0, WIN_RW_MASK}, RESP_OKAY);
        for (int f = 0; f < 4; f++) begin
            wr(IDX_WIN4, f << 6, RESP_OKAY);
            @(posedge aclk);
            check_val({30'h0, b16, bmux}, f);
        end
        wr(IDX_WIN4, 32'h003F, RESP_OKAY);
        wr(IDX_CMD, 32'h6, RESP_OKAY);
        rd(IDX_STAT, 32'h6, RESP_OKAY);
        wr(IDX_STAT, 32'h4, RESP_OKAY);
        rd(IDX_STAT, 32'h2, RESP_OKAY);
        $display("test registers done");
        for (int i = 0; i < 5; i++) begin
            run_cycle(tab[i][31:16], tab[i][15:0]);
            check_val({n_rd, n_wr, n_bhe, n_cs}, exp_n[i]);
        end
        $display("test cycles done");
        for (int p = 0; p < 2; p++) begin
            pol <= p[0];
            dly <= p[0] ? 4'h6 : 4'h1;
            run_cycle(16'h1430 | (p[15:0] << 13), 16'h6);
            check_val({31'h0, n_rd > {4'h0, dly} && n_rd < 8'd16}, 32'h1);
        end
        $display("test handshake done");
        ea <= 1'b0;
        aresetn <= 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd(IDX_WIN0, 32'h0680, RESP_OKAY);
        rd(IDX_WIN4, 32'h80, RESP_OKAY);
        run_cycle(16'h0, 16'h4);
        check_val({n_rd, n_wr, n_bhe, n_cs}, 32'h1000_0000);
        $display("test reset done");
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
